/* hw/slot_mailbox_pkg.sv */
// Constants, types and carriers shared by the slave slot mailbox design
// How it works
// - Each slave owns one contiguous twenty-byte slot
// - Multi-byte fields stored most significant byte first
// - Weight bytes go to outbound offsets two-five
// - Status words go to outbound bytes eight-eleven
// - Window address echo and three words follow
// - Error byte; 255 means communication failure
// - Command 200 writes up to eight registers
// - Command 201 selects a three-register read window
// - Window command ignores the register count byte
// - Power-fail status bit cleared by command 202
// - Act only when the command byte changes
// - Acknowledge with command code or error 250-255
// - Integer mode: signed weight plus decimals
// - Float mode: IEEE weight plus significant decimals
package slot_mailbox_pkg;

	localparam int          SLOT_BYTES      = 20;
	localparam int          NUM_SLAVES      = 16;
	localparam int          ADDR_W          = 9;
	localparam int          MEM_DEPTH       = 320;
	localparam int          WRITE_WORDS_MAX = 8;
	localparam int          WINDOW_WORDS    = 3;
	localparam int          PF_STATUS_BIT   = 4;

	localparam logic [4:0]  OFS_CMD         = 5'h00;
	localparam logic [4:0]  OFS_COUNT       = 5'h01;
	localparam logic [4:0]  OFS_ADDR_HI     = 5'h02;
	localparam logic [4:0]  OFS_ADDR_LO     = 5'h03;
	localparam logic [4:0]  OFS_WDATA       = 5'h04;
	localparam logic [4:0]  OFS_LAST        = 5'h13;
	localparam logic [4:0]  OFS_ACK         = 5'h00;
	localparam logic [4:0]  OFS_ERROR       = 5'h01;
	localparam logic [4:0]  OFS_WEIGHT      = 5'h02;
	localparam logic [4:0]  OFS_DECIMALS    = 5'h06;
	localparam logic [4:0]  OFS_STATUS1     = 5'h08;
	localparam logic [4:0]  OFS_STATUS2     = 5'h0a;
	localparam logic [4:0]  OFS_WIN_ECHO    = 5'h0c;
	localparam logic [4:0]  OFS_WIN_WORDS   = 5'h0e;

	localparam logic [7:0]  CMD_NONE        = 8'h00;
	localparam logic [7:0]  CMD_WRITE       = 8'hc8;
	localparam logic [7:0]  CMD_WINDOW      = 8'hc9;
	localparam logic [7:0]  CMD_CLEAR_PF    = 8'hca;
	localparam logic [7:0]  COUNT_MAX       = 8'h08;
	localparam logic [7:0]  ACK_ERR_MIN     = 8'hfa;
	localparam logic [7:0]  ACK_BAD_COUNT   = 8'hfa;
	localparam logic [7:0]  ERR_COMM_FAIL   = 8'hff;

	localparam logic [7:0]  LAST_CMD_RESET  = 8'h00;
	localparam logic [15:0] WIN_ADDR_RESET  = 16'h0000;
	localparam logic [3:0]  SLAVE_RESET     = 4'h0;

	typedef enum logic [1:0] {
		TXN_WRITE    = 2'h0,
		TXN_WINDOW   = 2'h1,
		TXN_CLEAR_PF = 2'h2,
		TXN_COMMAND  = 2'h3
	} txn_kind_t;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_CHECK  = 3'b001,
		ST_GATHER = 3'b011,
		ST_DECIDE = 3'b010,
		ST_ISSUE  = 3'b110,
		ST_WAIT   = 3'b111,
		ST_ACK    = 3'b101,
		ST_REPLY  = 3'b100
	} state_t;

	typedef struct packed {
		txn_kind_t    kind;
		logic [3:0]   slave;
		logic [7:0]   code;
		logic [7:0]   count;
		logic [15:0]  addr;
		logic [127:0] data;
	} txn_t;

	typedef struct packed {
		logic [3:0]   slave;
		logic         comm_fail;
		logic [7:0]   error;
		logic [31:0]  weight_int;
		logic [31:0]  weight_float;
		logic [15:0]  decimals;
		logic [15:0]  status1;
		logic [15:0]  status2;
		logic [47:0]  window_words;
	} reply_t;

endpackage

/* hw/slot_byte_ram.sv */
// Byte-wide memory with one write port and one registered read port
`timescale 1ns/1ps
`default_nettype none
module slot_byte_ram #(
	parameter int DEPTH  = 320,
	parameter int AW     = 9,
	parameter int WIDTH  = 8
) (
	input  wire logic             clk_sys_i,
	input  wire logic             resetn_i,
	input  wire logic             wr_en_i,
	input  wire logic [AW-1:0]    wr_addr_i,
	input  wire logic [WIDTH-1:0] wr_data_i,
	input  wire logic             rd_en_i,
	input  wire logic [AW-1:0]    rd_addr_i,
	output logic      [WIDTH-1:0] rd_data_o
);

	logic [WIDTH-1:0] mem_reg [DEPTH];

	// Addresses past the last slot are simply dropped
	always_ff @(posedge clk_sys_i) begin
		if (wr_en_i && (int'(wr_addr_i) < DEPTH)) begin
			mem_reg[wr_addr_i] <= wr_data_i;
		end
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rd_data_o <= '0;
		end else if (rd_en_i) begin
			if (int'(rd_addr_i) < DEPTH) begin
				rd_data_o <= mem_reg[rd_addr_i];
			end else begin
				rd_data_o <= '0;
			end
		end
	end

endmodule
`default_nettype wire

/* hw/slot_mailbox.sv */
// Per-slave command mailbox between the fieldbus memory and the serial poller
`timescale 1ns/1ps
`default_nettype none
module slot_mailbox #(
	parameter int NUM_SLAVES = 16
) (
	input  wire logic                       clk_sys_i,
	input  wire logic                       resetn_i,
	input  wire logic                       fb_wr_en_i,
	input  wire logic [8:0]                 fb_wr_addr_i,
	input  wire logic [7:0]                 fb_wr_data_i,
	input  wire logic                       fb_rd_en_i,
	input  wire logic [8:0]                 fb_rd_addr_i,
	output logic      [7:0]                 fb_rd_data_o,
	input  wire logic                       float_weight_i,
	output slot_mailbox_pkg::txn_t          txn_o,
	output logic                            txn_req_o,
	input  wire logic                       txn_done_i,
	input  wire logic                       txn_fail_i,
	input  wire logic [7:0]                 txn_fail_code_i,
	input  wire logic                       reply_valid_i,
	input  wire slot_mailbox_pkg::reply_t   reply_i,
	output logic                            reply_ready_o
);
	import slot_mailbox_pkg::*;

	state_t           state_reg;
	logic [3:0]       slave_reg;
	logic [4:0]       idx_reg;
	logic [7:0]       cmd_reg;
	logic [7:0]       ack_reg;
	logic [7:0]       opb_reg [1:SLOT_BYTES-1];
	reply_t           reply_reg;
	logic             reply_flt_reg;
	logic [15:0]      reply_win_reg;
	logic [7:0]       last_cmd_reg [NUM_SLAVES];
	logic [15:0]      win_addr_reg [NUM_SLAVES];

	logic [8:0]       base;
	logic [8:0]       in_rd_addr;
	logic             in_rd_en;
	logic [7:0]       in_rd_data;
	logic             out_wr_en;
	logic [8:0]       out_wr_addr;
	logic [7:0]       out_wr_data;
	logic             cmd_changed;
	logic             last_slave;
	logic [7:0]       fail_code;
	logic [7:0]       image_byte;
	logic [159:0]     image;
	logic [31:0]      weight_sel;
	logic [127:0]     wdata;

	// Slot n starts at twenty times n; done with shifts to stay cheap
	always_comb begin
		base = {1'b0, slave_reg, 4'h0} + {3'b000, slave_reg, 2'b00};
	end

	assign last_slave  = (int'(slave_reg) == NUM_SLAVES - 1);
	assign cmd_changed = (in_rd_data != last_cmd_reg[slave_reg]);

	// Codes below the error range from the poller are folded to comm failure
	assign fail_code = (txn_fail_code_i >= ACK_ERR_MIN) ? txn_fail_code_i : ERR_COMM_FAIL;

	// Inbound memory: written by the fieldbus, read by the command scanner
	always_comb begin
		in_rd_en   = 1'b0;
		in_rd_addr = base + {4'h0, OFS_CMD};
		case (state_reg)
			ST_IDLE: begin
				in_rd_en   = !(reply_valid_i && reply_ready_o);
				in_rd_addr = base + {4'h0, OFS_CMD};
			end
			ST_CHECK: begin
				in_rd_en   = 1'b1;
				in_rd_addr = base + {4'h0, OFS_COUNT};
			end
			ST_GATHER: begin
				in_rd_en   = (idx_reg != OFS_LAST);
				in_rd_addr = base + {4'h0, idx_reg} + 9'h001;
			end
			default: begin
				in_rd_en   = 1'b0;
				in_rd_addr = base;
			end
		endcase
	end

	slot_byte_ram #(
		.DEPTH     (MEM_DEPTH),
		.AW        (ADDR_W),
		.WIDTH     (8)
	) u_inbound (
		.clk_sys_i (clk_sys_i),
		.resetn_i  (resetn_i),
		.wr_en_i   (fb_wr_en_i),
		.wr_addr_i (fb_wr_addr_i),
		.wr_data_i (fb_wr_data_i),
		.rd_en_i   (in_rd_en),
		.rd_addr_i (in_rd_addr),
		.rd_data_o (in_rd_data)
	);

	// Outbound image of the latest reply, most significant byte first
	always_comb begin
		weight_sel = reply_flt_reg ? reply_reg.weight_float : reply_reg.weight_int;
		image = {
			8'h00,
			(reply_reg.comm_fail ? ERR_COMM_FAIL : reply_reg.error),
			weight_sel,
			reply_reg.decimals,
			reply_reg.status1,
			reply_reg.status2,
			reply_win_reg,
			reply_reg.window_words
		};
		image_byte = image[159 - 8 * int'(idx_reg) -: 8];
	end

	always_comb begin
		out_wr_en   = 1'b0;
		out_wr_addr = base;
		out_wr_data = 8'h00;
		case (state_reg)
			ST_ACK: begin
				out_wr_en   = 1'b1;
				out_wr_addr = base + {4'h0, OFS_ACK};
				out_wr_data = ack_reg;
			end
			ST_REPLY: begin
				out_wr_en   = 1'b1;
				out_wr_addr = base + {4'h0, idx_reg};
				out_wr_data = image_byte;
			end
			default: begin
				out_wr_en   = 1'b0;
				out_wr_addr = base;
				out_wr_data = 8'h00;
			end
		endcase
	end

	slot_byte_ram #(
		.DEPTH     (MEM_DEPTH),
		.AW        (ADDR_W),
		.WIDTH     (8)
	) u_outbound (
		.clk_sys_i (clk_sys_i),
		.resetn_i  (resetn_i),
		.wr_en_i   (out_wr_en),
		.wr_addr_i (out_wr_addr),
		.wr_data_i (out_wr_data),
		.rd_en_i   (fb_rd_en_i),
		.rd_addr_i (fb_rd_addr_i),
		.rd_data_o (fb_rd_data_o)
	);

	// Scanner and command sequencer; replies are taken only between commands
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_reg <= ST_IDLE;
			slave_reg <= SLAVE_RESET;
			idx_reg   <= OFS_CMD;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (reply_valid_i && reply_ready_o) begin
						state_reg <= ST_REPLY;
						slave_reg <= reply_i.slave;
						idx_reg   <= OFS_ERROR;
					end else begin
						state_reg <= ST_CHECK;
					end
				end
				ST_CHECK: begin
					if (cmd_changed) begin
						state_reg <= ST_GATHER;
						idx_reg   <= OFS_COUNT;
					end else begin
						state_reg <= ST_IDLE;
						slave_reg <= last_slave ? SLAVE_RESET : slave_reg + 4'h1;
					end
				end
				ST_GATHER: begin
					if (idx_reg == OFS_LAST) begin
						state_reg <= ST_DECIDE;
					end else begin
						idx_reg <= idx_reg + 5'h01;
					end
				end
				ST_DECIDE: begin
					if (cmd_reg == CMD_NONE) begin
						state_reg <= ST_ACK;
					end else if ((cmd_reg == CMD_WRITE) &&
							((opb_reg[OFS_COUNT] == 8'h00) || (opb_reg[OFS_COUNT] > COUNT_MAX))) begin
						state_reg <= ST_ACK;
					end else begin
						state_reg <= ST_ISSUE;
					end
				end
				ST_ISSUE: begin
					state_reg <= ST_WAIT;
				end
				ST_WAIT: begin
					if (txn_done_i || txn_fail_i) begin
						state_reg <= ST_ACK;
					end
				end
				ST_ACK: begin
					state_reg <= ST_IDLE;
					slave_reg <= last_slave ? SLAVE_RESET : slave_reg + 4'h1;
				end
				ST_REPLY: begin
					if (idx_reg == OFS_LAST) begin
						state_reg <= ST_IDLE;
						slave_reg <= SLAVE_RESET;
					end else begin
						idx_reg <= idx_reg + 5'h01;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// Command byte latched on every scan check; operands latched once the command byte has moved
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cmd_reg <= CMD_NONE;
			for (int i = 1; i < SLOT_BYTES; i++) begin
				opb_reg[i] <= 8'h00;
			end
		end else if (state_reg == ST_CHECK) begin
			cmd_reg <= in_rd_data;
		end else if (state_reg == ST_GATHER) begin
			opb_reg[idx_reg] <= in_rd_data;
		end
	end

	// Acknowledge value: code when performed, error code otherwise
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ack_reg <= CMD_NONE;
		end else if (state_reg == ST_DECIDE) begin
			if (cmd_reg == CMD_WRITE) begin
				ack_reg <= ACK_BAD_COUNT;
			end else begin
				ack_reg <= cmd_reg;
			end
		end else if ((state_reg == ST_WAIT) && txn_done_i) begin
			ack_reg <= cmd_reg;
		end else if ((state_reg == ST_WAIT) && txn_fail_i) begin
			ack_reg <= fail_code;
		end
	end

	// Write words packed in slot order, high byte of each word first
	always_comb begin
		wdata = '0;
		for (int w = 0; w < WRITE_WORDS_MAX; w++) begin
			wdata[127 - 16 * w -: 16] = {opb_reg[int'(OFS_WDATA) + 2 * w],
				opb_reg[int'(OFS_WDATA) + 2 * w + 1]};
		end
	end

	// Transaction request: one pulse per command change, none for code 0 or a bad write count
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			txn_req_o <= 1'b0;
			txn_o     <= '0;
		end else begin
			txn_req_o <= (state_reg == ST_DECIDE) && (cmd_reg != CMD_NONE) &&
				!((cmd_reg == CMD_WRITE) &&
				((opb_reg[OFS_COUNT] == 8'h00) || (opb_reg[OFS_COUNT] > COUNT_MAX)));
			if (state_reg == ST_DECIDE) begin
				txn_o.slave <= slave_reg;
				txn_o.code  <= cmd_reg;
				txn_o.addr  <= {opb_reg[OFS_ADDR_HI], opb_reg[OFS_ADDR_LO]};
				txn_o.data  <= wdata;
				if (cmd_reg == CMD_WRITE) begin
					txn_o.kind  <= TXN_WRITE;
					txn_o.count <= opb_reg[OFS_COUNT];
				end else if (cmd_reg == CMD_WINDOW) begin
					txn_o.kind  <= TXN_WINDOW;
					txn_o.count <= 8'(WINDOW_WORDS);
				end else if (cmd_reg == CMD_CLEAR_PF) begin
					txn_o.kind  <= TXN_CLEAR_PF;
					txn_o.count <= 8'h00;
				end else begin
					txn_o.kind  <= TXN_COMMAND;
					txn_o.count <= 8'h00;
				end
			end
		end
	end

	// Reply capture; the poller is held off while a command is in flight
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			reply_ready_o <= 1'b0;
			reply_reg     <= '0;
			reply_flt_reg <= 1'b0;
			reply_win_reg <= WIN_ADDR_RESET;
		end else begin
			reply_ready_o <= (state_reg == ST_ACK) || (state_reg == ST_CHECK && !cmd_changed) ||
				(state_reg == ST_REPLY && idx_reg == OFS_LAST);
			if (reply_valid_i && reply_ready_o && (state_reg == ST_IDLE)) begin
				reply_ready_o <= 1'b0;
				reply_reg     <= reply_i;
				reply_flt_reg <= float_weight_i;
				reply_win_reg <= win_addr_reg[reply_i.slave];
			end
		end
	end

	// Per-slave memory of the last command seen and the active read window
	for (genvar s = 0; s < NUM_SLAVES; s++) begin : g_slave
		always_ff @(posedge clk_sys_i or negedge resetn_i) begin
			if (!resetn_i) begin
				last_cmd_reg[s] <= LAST_CMD_RESET;
			end else if ((state_reg == ST_CHECK) && (int'(slave_reg) == s)) begin
				last_cmd_reg[s] <= in_rd_data;
			end
		end

		always_ff @(posedge clk_sys_i or negedge resetn_i) begin
			if (!resetn_i) begin
				win_addr_reg[s] <= WIN_ADDR_RESET;
			end else if ((state_reg == ST_WAIT) && txn_done_i && (cmd_reg == CMD_WINDOW) &&
					(int'(slave_reg) == s)) begin
				win_addr_reg[s] <= {opb_reg[OFS_ADDR_HI], opb_reg[OFS_ADDR_LO]};
			end
		end
	end

endmodule
`default_nettype wire

/* verif/slot_mailbox_properties.sv */
// Port-level assertions for the slave slot mailbox
`timescale 1ns/1ps
`default_nettype none
module slot_mailbox_properties
	import slot_mailbox_pkg::*;
(
	input wire logic                 clk_sys_i,
	input wire logic                 resetn_i,
	input wire logic                 fb_rd_en_i,
	input wire logic [7:0]           fb_rd_data_o,
	input wire slot_mailbox_pkg::txn_t txn_o,
	input wire logic                 txn_req_o,
	input wire logic                 reply_ready_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);
	// A new command needs a full gather, so requests are far apart
	property p_req_spacing; txn_req_o |=> (!txn_req_o)[*8]; endproperty
	a_req_spacing: assert property (p_req_spacing) else $error("request repeated");
	property p_write_code;
		txn_req_o && txn_o.kind == TXN_WRITE |-> txn_o.code == CMD_WRITE;
	endproperty
	a_write_code: assert property (p_write_code) else $error("write kind code");
	property p_write_count;
		txn_req_o && txn_o.kind == TXN_WRITE |-> txn_o.count inside {[8'h01:COUNT_MAX]};
	endproperty
	a_write_count: assert property (p_write_count) else $error("write count range");
	property p_window_count;
		txn_req_o && txn_o.kind == TXN_WINDOW |-> txn_o.count == 8'h03 && txn_o.code == CMD_WINDOW;
	endproperty
	a_window_count: assert property (p_window_count) else $error("window width");
	property p_clear_code;
		txn_req_o && txn_o.kind == TXN_CLEAR_PF |-> txn_o.code == CMD_CLEAR_PF;
	endproperty
	a_clear_code: assert property (p_clear_code) else $error("clear code");
	property p_other_code;
		txn_req_o && txn_o.kind == TXN_COMMAND |-> !(txn_o.code inside {8'h00, 8'hc8, 8'hc9, 8'hca});
	endproperty
	a_other_code: assert property (p_other_code) else $error("plain command code");
	property p_txn_hold; txn_req_o |=> $stable(txn_o)[*4]; endproperty
	a_txn_hold: assert property (p_txn_hold) else $error("transaction changed");
	property p_rd_hold; !fb_rd_en_i |=> $stable(fb_rd_data_o); endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	// Replies must not overwrite a slot while its command is in flight
	property p_ready_inflight; txn_req_o |=> !reply_ready_o; endproperty
	a_ready_inflight: assert property (p_ready_inflight) else $error("reply taken in flight");
	c_write: cover property (txn_req_o && txn_o.kind == TXN_WRITE);
	c_window: cover property (txn_req_o && txn_o.kind == TXN_WINDOW);
	c_clear: cover property (txn_req_o && txn_o.kind == TXN_CLEAR_PF);
endmodule
bind slot_mailbox slot_mailbox_properties u_props (.clk_sys_i, .resetn_i, .fb_rd_en_i,
	.fb_rd_data_o, .txn_o, .txn_req_o, .reply_ready_o);
`default_nettype wire

/* verif/slot_poller_model.sv */
// Serial poller stand-in: answers transactions and offers slave replies
`timescale 1ns/1ps
`default_nettype none
module slot_poller_model
	import slot_mailbox_pkg::*;
(
	input  wire logic                   clk_sys_i,
	input  wire slot_mailbox_pkg::txn_t txn_i,
	input  wire logic                   txn_req_i,
	output logic                        txn_done_o,
	output logic                        txn_fail_o,
	output logic [7:0]                  txn_fail_code_o,
	output logic                        reply_valid_o,
	output slot_mailbox_pkg::reply_t    reply_o,
	input  wire logic                   reply_ready_i
);
	int         delay_cyc = 3;
	logic [7:0] fail_code = 8'h00;
	int         txn_count = 0;
	txn_t       last_txn;
	initial begin
		txn_done_o = 1'b0;
		txn_fail_o = 1'b0;
		txn_fail_code_o = 8'h00;
		reply_valid_o = 1'b0;
		reply_o = '0;
	end
	// One answer per issued transaction; a nonzero fail_code makes it fail
	always @(posedge clk_sys_i) begin
		if (txn_req_i === 1'b1) begin
			txn_count++;
			last_txn = txn_i;
			repeat (delay_cyc) @(posedge clk_sys_i);
			#1;
			txn_done_o = (fail_code == 8'h00);
			txn_fail_o = (fail_code != 8'h00);
			txn_fail_code_o = fail_code;
			@(posedge clk_sys_i);
			#1;
			txn_done_o = 1'b0;
			txn_fail_o = 1'b0;
			txn_fail_code_o = ~fail_code;
		end
	end
	// Reply is held until taken; afterwards the bus shows other bits
	task automatic send_reply(input reply_t r);
		@(posedge clk_sys_i);
		#1;
		reply_o = r;
		reply_valid_o = 1'b1;
		do @(posedge clk_sys_i); while (reply_ready_i !== 1'b1);
		#1;
		reply_valid_o = 1'b0;
		reply_o = ~r;
	endtask
endmodule
`default_nettype wire

/* verif/slot_mailbox_tb_top.sv */
// Self-checking bench for the slave slot mailbox
`timescale 1ns/1ps
`default_nettype none
module slot_mailbox_tb_top;
	import slot_mailbox_pkg::*;
	logic         clk_sys_i = 1'b0;
	logic         resetn_i = 1'b0;
	logic         fb_wr_en_i = 1'b0;
	logic [8:0]   fb_wr_addr_i = 9'h000;
	logic [7:0]   fb_wr_data_i = 8'h00;
	logic         fb_rd_en_i = 1'b0;
	logic [8:0]   fb_rd_addr_i = 9'h000;
	logic [7:0]   fb_rd_data_o;
	logic         float_weight_i = 1'b0;
	txn_t         txn_o;
	logic         txn_req_o;
	logic         txn_done_i;
	logic         txn_fail_i;
	logic [7:0]   txn_fail_code_i;
	logic         reply_valid_i;
	reply_t       reply_i;
	logic         reply_ready_o;
	logic [127:0] wdata;
	logic [15:0]  exp_win [16];
	int           err_total = 0;
	int           comparisons = 0;
	always #4 clk_sys_i = ~clk_sys_i;
	slot_mailbox #(.NUM_SLAVES(16)) dut (.clk_sys_i, .resetn_i, .fb_wr_en_i, .fb_wr_addr_i,
		.fb_wr_data_i, .fb_rd_en_i, .fb_rd_addr_i, .fb_rd_data_o, .float_weight_i, .txn_o,
		.txn_req_o, .txn_done_i, .txn_fail_i, .txn_fail_code_i, .reply_valid_i, .reply_i,
		.reply_ready_o);
	slot_poller_model model (.clk_sys_i, .txn_i(txn_o), .txn_req_i(txn_req_o),
		.txn_done_o(txn_done_i), .txn_fail_o(txn_fail_i), .txn_fail_code_o(txn_fail_code_i),
		.reply_valid_o(reply_valid_i), .reply_o(reply_i), .reply_ready_i(reply_ready_o));
	task automatic check(input string what, input logic [127:0] e, input logic [127:0] g);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s expected %0h seen %0h", what, e, g);
		end
	endtask
	task automatic wr_byte(input logic [8:0] a, input logic [7:0] v);
		@(posedge clk_sys_i);
		#1;
		fb_wr_en_i = 1'b1;
		fb_wr_addr_i = a;
		fb_wr_data_i = v;
		@(posedge clk_sys_i);
		#1;
		fb_wr_en_i = 1'b0;
	endtask
	task automatic rd_byte(input logic [8:0] a, output logic [7:0] d);
		@(posedge clk_sys_i);
		#1;
		fb_rd_en_i = 1'b1;
		fb_rd_addr_i = a;
		@(posedge clk_sys_i);
		#1;
		fb_rd_en_i = 1'b0;
		d = fb_rd_data_o;
	endtask
	// Operands first, command byte last; then poll the acknowledgement
	task automatic do_cmd(input int s, input logic [7:0] code, input logic [7:0] cnt,
		input logic [15:0] adr, input logic [7:0] ack, input bit fire);
		int n;
		logic [7:0] d;
		txn_kind_t k;
		n = model.txn_count;
		wdata = {$urandom, $urandom, $urandom, $urandom};
		model.delay_cyc = $urandom_range(1, 20);
		wr_byte(9'(s * 20 + 1), cnt);
		wr_byte(9'(s * 20 + 2), adr[15:8]);
		wr_byte(9'(s * 20 + 3), adr[7:0]);
		for (int i = 0; i < 16; i++) wr_byte(9'(s * 20 + 4 + i), wdata[127 - 8 * i -: 8]);
		wr_byte(9'(s * 20), code);
		d = ~ack;
		for (int t = 0; t < 300 && d !== ack; t++) rd_byte(9'(s * 20), d);
		check("ack byte", ack, d);
		repeat (60) @(posedge clk_sys_i);
		#1;
		check("txn count", n + fire, model.txn_count);
		if (code == CMD_WINDOW && ack == CMD_WINDOW) exp_win[s] = adr;
		k = (code == CMD_WRITE) ? TXN_WRITE : (code == CMD_WINDOW) ? TXN_WINDOW :
			(code == CMD_CLEAR_PF) ? TXN_CLEAR_PF : TXN_COMMAND;
		if (fire) begin
			check("txn head", {k, 4'(s), code}, {model.last_txn.kind,
				model.last_txn.slave, model.last_txn.code});
			if (k != TXN_COMMAND && k != TXN_CLEAR_PF)
				check("txn args", {(k == TXN_WINDOW) ? 8'h03 : cnt, adr},
					{model.last_txn.count, model.last_txn.addr});
			if (k == TXN_WRITE) check("txn data", wdata, model.last_txn.data);
		end
	endtask
	// Reply fields land in bytes 01..19 most significant first
	task automatic do_reply(input int s, input logic [1:0] j);
		reply_t r;
		logic [159:0] rb;
		logic [7:0] d;
		// Six random words are wider than the reply; the top bits are cut on purpose
		r = $bits(reply_t)'({$urandom, $urandom, $urandom, $urandom, $urandom, $urandom});
		r.slave = 4'(s);
		r.comm_fail = j[1];
		float_weight_i = j[0];
		model.send_reply(r);
		rb = {8'h00, r.comm_fail ? 8'hff : r.error, j[0] ? r.weight_float : r.weight_int,
			r.decimals, r.status1, r.status2, exp_win[s], r.window_words};
		repeat (30) @(posedge clk_sys_i);
		for (int i = 1; i < 20; i++) begin
			rd_byte(9'(s * 20 + i), d);
			check("reply byte", rb[159 - 8 * i -: 8], d);
		end
	endtask
	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		int s;
		logic [7:0] d;
		void'($urandom(32'hcc62));
		foreach (exp_win[i]) exp_win[i] = 16'h0000;
		repeat (12) @(posedge clk_sys_i);
		#1;
		resetn_i = 1'b1;
		// Memories power up unknown, so every inbound byte is cleared first
		for (int a = 0; a < 320; a++) wr_byte(9'(a), 8'h00);
		for (int k = 0; k < 3; k++) begin
			s = (k == 0) ? 0 : (k == 1) ? 15 : $urandom_range(1, 14);
			d = (k == 0) ? 8'h01 : (k == 1) ? 8'h08 : 8'($urandom_range(2, 7));
			do_cmd(s, CMD_WRITE, d, 16'($urandom), CMD_WRITE, 1);
		end
		do_cmd(s, CMD_WRITE, 8'h02, 16'($urandom), CMD_WRITE, 0);
		for (int k = 0; k < 2; k++) begin
			do_cmd(s, CMD_NONE, 8'h01, 16'h0000, CMD_NONE, 0);
			do_cmd(s, CMD_WRITE, k ? 8'h00 : 8'h09, 16'h0000, ACK_BAD_COUNT, 0);
		end
		do_cmd(s, CMD_WINDOW, 8'($urandom), 16'($urandom), CMD_WINDOW, 1);
		do_cmd(s, CMD_CLEAR_PF, 8'h00, 16'h0000, CMD_CLEAR_PF, 1);
		do_cmd(s, 8'h07, 8'h00, 16'h0000, 8'h07, 1);
		model.fail_code = 8'h0c;
		do_cmd(s, CMD_WINDOW, 8'h05, 16'($urandom), ERR_COMM_FAIL, 1);
		model.fail_code = 8'hfb;
		do_cmd(s, CMD_CLEAR_PF, 8'h00, 16'h0000, 8'hfb, 1);
		model.fail_code = 8'h00;
		for (int j = 0; j < 4; j++) do_reply(s, 2'(j));
		rd_byte(9'h140, d);
		check("unmapped read", 8'h00, d);
		test_done();
	end
	initial begin
		#160000;
		err_total++;
		test_done();
	end
endmodule
`default_nettype wire
